// ===== src/sys_protect_pkg.sv
// Constants, register map and carrier types of the system protection block
package sys_protect_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [3:0] CTRL_OFS    = 4'h0;
    localparam logic [3:0] SVC_OFS     = 4'h4;
    localparam logic [3:0] CAUSE_OFS   = 4'h8;
    localparam logic [3:0] STATUS_OFS  = 4'hC;

    // Values after reset
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [1:0] CAUSE_RESET = 2'h0;

    // Service sequence bytes
    localparam logic [7:0] SVC_FIRST   = 8'h55;
    localparam logic [7:0] SVC_SECOND  = 8'hAA;

    // Reset cause bit positions
    localparam int CAUSE_HALT_BIT = 0;
    localparam int CAUSE_WDOG_BIT = 1;

    // Watchdog timing: ratio 2^(base + 2*timing), times 512 when prescaled
    localparam int WDOG_BASE_LOG2   = 9;
    localparam int WDOG_PRESCALE    = 512;
    localparam int WDOG_CNT_W       = 16;
    localparam int PRESCALE_CNT_W   = 9;

    // Bus monitor longest window is 64 system clocks
    localparam logic [6:0] BMON_MAX = 7'h40;

    // Width of the system reset pulse we issue, in clock cycles
    localparam logic [4:0] RST_PULSE_CYCLES = 5'h10;

    // System clocks per synthesizer reference period (arbitrary default)
    localparam int REF_DIV_DEFAULT = 24;

    // Protection control layout, MSB first
    typedef struct packed {
        logic       wdog_enable_bit;
        logic       wdog_prescale_sel;
        logic [1:0] wdog_timing_sel;
        logic       halt_mon_enable;
        logic       bus_mon_enable;
        logic [1:0] bus_mon_timing_sel;
    } ctrl_t;

    // One bus cycle as seen by the monitors
    typedef struct packed {
        logic       active;
        logic       to_external;
        logic       own_cpu;
        logic       interrupt_acknowledge_cycle;
        logic       transfer_acknowledge;
        logic       arb_end;
        logic [3:0] interrupt_arbitration_id;
    } bus_cycle_t;

    typedef enum logic [1:0] {
        SVC_IDLE  = 2'b00,
        SVC_ARMED = 2'b01
    } svc_state_t;

endpackage

// ===== src/system_protection_monitors.sv
// Watchdog, bus, halt and spurious interrupt monitors with register slave
// Summary of operation
// [RULE1] Prescale bit divides watchdog clock by 512
// [RULE2] Prescale bit loads inverted mode pin at reset
// [RULE3] Ratio from prescale and timing field codes
// [RULE4] Timeout counted in reference clock periods
// [RULE5] Watchdog runs only while enable bit set
// [RULE6] Writing 55 then AA restarts watchdog
// [RULE7] Software services both writes before timeout
// [RULE8] Unserviced enabled watchdog timeout issues system reset
// [RULE9] Service register always writable, reads zero
// [RULE10] New timing takes effect after next service
// [RULE11] Bus timeout 64, 32, 16, 8 clocks
// [RULE12] Missing acknowledge within timeout raises bus error
// [RULE13] External cycles monitored only with enable bit
// [RULE14] Foreign-master external cycles are never timed
// [RULE15] External masters need own monitor, ours off
// [RULE16] Halt after double fault resets the device
// [RULE17] Halt-caused reset recorded in cause register
// [RULE18] Halt reset suppressed while halt enable clear
// [RULE19] Interrupt_acknowledge_cycle without arbitration participant raises bus error
// [RULE20] Control register written once, always readable
// [RULE21] Enable bit: 0 disables, 1 enables watchdog
// [RULE22] Lone AA or other bytes change nothing
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module system_protection_monitors #(
    parameter int REF_DIV   = sys_protect_pkg::REF_DIV_DEFAULT,
    parameter int BASE_LOG2 = sys_protect_pkg::WDOG_BASE_LOG2,
    parameter int PRESCALE  = sys_protect_pkg::WDOG_PRESCALE
) (
    input  wire logic                        clock_in,
    input  wire logic                        rst_n_in,
    input  wire logic [3:0]                  address_in,
    input  wire logic                        read_in,
    input  wire logic                        write_in,
    input  wire logic [31:0]                 writedata_in,
    input  wire logic [3:0]                  byteenable_in,
    output logic [31:0]                      readdata_out,
    output logic                             waitrequest_out,
    input  wire logic                        clock_mode_pin_in,
    input  wire logic                        halt_in,
    input  wire sys_protect_pkg::bus_cycle_t bus_cycle_in,
    output logic                             bus_error_signal_out,
    output logic                             sys_reset_out
);
    import sys_protect_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic       rst_meta_r;
    logic       rst_n;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ctrl_t                   ctrl_r;
    logic                    ctrl_written_r;
    logic                    mode_pend_r;
    logic [1:0]              timing_act_r;
    svc_state_t              svc_state_r;
    logic [1:0]              cause_r;
    logic [4:0]              rst_cnt_r;
    logic                    ack_r;
    logic [31:0]             readdata_r;
    logic [15:0]             ref_cnt_r;
    logic [PRESCALE_CNT_W-1:0] pre_cnt_r;
    logic [WDOG_CNT_W-1:0]   wd_cnt_r;
    logic [WDOG_CNT_W-1:0]   wd_last;
    logic [6:0]              bm_cnt_r;
    logic [6:0]              bm_last;
    logic                    bm_fired_r;
    logic                    bus_error_signal_r;

    logic req;
    logic acc_wr;
    logic acc_rd;
    logic svc_wr;
    logic svc_restart;
    logic ref_tick;
    logic pre_tick;
    logic wd_expire;
    logic halt_trig;
    logic trigger;
    logic in_reset;
    logic monitored;
    logic bm_fire;
    logic spurious;

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait state, answer on the second edge
    assign req    = read_in | write_in;
    assign acc_wr = write_in & ack_r;
    assign acc_rd = read_in & ack_r;
    assign waitrequest_out = req & ~ack_r;
    assign readdata_out    = readdata_r;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            readdata_r <= 32'h0000_0000;
        end else if (read_in & ~ack_r) begin
            case (address_in)
                CTRL_OFS:   readdata_r <= {24'h00_0000, ctrl_r}; // [RULE20]
                CAUSE_OFS:  readdata_r <= {30'h0000_0000, cause_r};
                STATUS_OFS: readdata_r <= {28'h000_0000, timing_act_r,
                                           svc_state_r == SVC_ARMED,
                                           ctrl_written_r};
                default:    readdata_r <= 32'h0000_0000; // [RULE9]
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Protection control, write-once, cleared again by our own resets
    assign in_reset = rst_cnt_r != 5'h00;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r         <= CTRL_RESET;
            ctrl_written_r <= 1'b0;
            mode_pend_r    <= 1'b1;
        end else if (trigger) begin
            ctrl_r         <= CTRL_RESET;
            ctrl_written_r <= 1'b0;
            mode_pend_r    <= 1'b1;
        end else if (mode_pend_r && !in_reset) begin
            // Pin caught on the first edge after release
            ctrl_r.wdog_prescale_sel <= ~clock_mode_pin_in; // [RULE2]
            mode_pend_r              <= 1'b0;
        end else if (acc_wr && address_in == CTRL_OFS && byteenable_in[0]
                     && !ctrl_written_r) begin
            ctrl_r         <= writedata_in[7:0]; // [RULE20]
            ctrl_written_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Service sequence
    assign svc_wr = acc_wr && address_in == SVC_OFS && byteenable_in[0];
    assign svc_restart = svc_wr && writedata_in[7:0] == SVC_SECOND
                         && svc_state_r == SVC_ARMED; // [RULE6]

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            svc_state_r <= SVC_IDLE;
        end else if (trigger) begin
            svc_state_r <= SVC_IDLE;
        end else if (svc_wr) begin
            case (svc_state_r)
                SVC_IDLE: begin
                    // A lone second byte is ignored
                    if (writedata_in[7:0] == SVC_FIRST) begin
                        svc_state_r <= SVC_ARMED; // [RULE22]
                    end
                end
                SVC_ARMED: begin
                    if (writedata_in[7:0] == SVC_SECOND) begin
                        svc_state_r <= SVC_IDLE; // [RULE6]
                    end
                end
                default: svc_state_r <= SVC_IDLE;
            endcase
        end
    end

    // Timing field reaches the counter on a completed service, and while mode_pend_r is set after a reset
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            timing_act_r <= CTRL_RESET[5:4];
        end else if (trigger) begin
            timing_act_r <= CTRL_RESET[5:4];
        end else if (svc_restart || mode_pend_r) begin
            timing_act_r <= ctrl_r.wdog_timing_sel; // [RULE10]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog clocking: reference tick, optional 512 prescaler
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt_r <= 16'h0000;
        end else if (ref_tick) begin
            ref_cnt_r <= 16'h0000;
        end else begin
            ref_cnt_r <= ref_cnt_r + 16'h0001;
        end
    end
    assign ref_tick = ref_cnt_r == 16'(REF_DIV - 1); // [RULE4]

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_r <= '0;
        end else if (svc_restart || !ctrl_r.wdog_enable_bit || in_reset) begin
            pre_cnt_r <= '0;
        end else if (ref_tick) begin
            pre_cnt_r <= (pre_cnt_r == PRESCALE_CNT_W'(PRESCALE - 1))
                         ? '0 : pre_cnt_r + 1'b1;
        end
    end
    assign pre_tick = ctrl_r.wdog_prescale_sel
        ? (ref_tick && pre_cnt_r == PRESCALE_CNT_W'(PRESCALE - 1))
        : ref_tick; // [RULE1]

    // Ratio 2^(9+2t), or 512 times that with prescale
    always_comb begin
        wd_last = WDOG_CNT_W'((32'h1 << (BASE_LOG2 + 2 * int'(timing_act_r)))
                              - 32'h1); // [RULE3]
    end

    assign wd_expire = ctrl_r.wdog_enable_bit && !in_reset && pre_tick
                       && wd_cnt_r == wd_last; // [RULE8] [RULE21]

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt_r <= '0;
        end else if (svc_restart || trigger || !ctrl_r.wdog_enable_bit) begin
            wd_cnt_r <= '0; // [RULE5] [RULE6]
        end else if (pre_tick && !in_reset) begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Halt monitor and system reset pulse
    assign halt_trig = halt_in && ctrl_r.halt_mon_enable
                       && !in_reset; // [RULE16] [RULE18]
    assign trigger   = wd_expire || halt_trig;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_r <= 5'h00;
        end else if (trigger) begin
            rst_cnt_r <= RST_PULSE_CYCLES; // [RULE8] [RULE16]
        end else if (in_reset) begin
            rst_cnt_r <= rst_cnt_r - 5'h01;
        end
    end
    assign sys_reset_out = in_reset;

    // Cause flags survive our own pulse; write one to clear, set wins
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            cause_r <= CAUSE_RESET;
        end else begin
            if (acc_wr && address_in == CAUSE_OFS && byteenable_in[0]) begin
                cause_r <= cause_r & ~writedata_in[1:0];
            end
            if (halt_trig) begin
                cause_r[CAUSE_HALT_BIT] <= 1'b1; // [RULE17]
            end
            if (wd_expire) begin
                cause_r[CAUSE_WDOG_BIT] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus monitor and spurious interrupt monitor
    // External cycles of other masters are never timed; own externals need enable
    assign monitored = bus_cycle_in.active && (!bus_cycle_in.to_external
        || (bus_cycle_in.own_cpu
            && ctrl_r.bus_mon_enable)); // [RULE13] [RULE14] [RULE15]

    always_comb begin
        bm_last = (BMON_MAX >> ctrl_r.bus_mon_timing_sel) - 7'h01; // [RULE11]
    end

    assign bm_fire = monitored && !bm_fired_r
                     && !bus_cycle_in.transfer_acknowledge
                     && bm_cnt_r == bm_last; // [RULE12]

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            bm_cnt_r   <= 7'h00;
            bm_fired_r <= 1'b0;
        end else if (!bus_cycle_in.active
                     || bus_cycle_in.transfer_acknowledge) begin
            bm_cnt_r   <= 7'h00;
            bm_fired_r <= 1'b0;
        end else if (monitored && !bm_fired_r) begin
            bm_cnt_r   <= bm_cnt_r + 7'h01;
            bm_fired_r <= bm_fire;
        end
    end

    // An arbitration result of zero means nobody answered
    assign spurious = bus_cycle_in.active && bus_cycle_in.interrupt_acknowledge_cycle
        && bus_cycle_in.arb_end
        && bus_cycle_in.interrupt_arbitration_id == 4'h0; // [RULE19]

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            bus_error_signal_r <= 1'b0;
        end else begin
            bus_error_signal_r <= bm_fire || spurious; // [RULE12] [RULE19]
        end
    end
    assign bus_error_signal_out = bus_error_signal_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n);

    property p_svc_restart;
        svc_restart && !trigger |=> wd_cnt_r == '0 && svc_state_r == SVC_IDLE;
    endproperty
    a_svc_restart: assert property (p_svc_restart) // [RULE6]
        else $error("service sequence did not restart watchdog");

    property p_lone_second;
        svc_wr && svc_state_r == SVC_IDLE && writedata_in[7:0] == SVC_SECOND
        && !trigger && ctrl_r.wdog_enable_bit && wd_cnt_r > 16'h0001
        |=> wd_cnt_r != '0 && svc_state_r == SVC_IDLE;
    endproperty
    a_lone_second: assert property (p_lone_second) // [RULE22]
        else $error("lone second byte restarted watchdog");

    property p_ctrl_once;
        acc_wr && address_in == CTRL_OFS && ctrl_written_r && !trigger
        |=> $stable(ctrl_r);
    endproperty
    a_ctrl_once: assert property (p_ctrl_once) // [RULE20]
        else $error("protection control changed after first write");

    property p_svc_reads_zero;
        acc_rd && address_in == SVC_OFS |-> readdata_out == 32'h0000_0000;
    endproperty
    a_svc_reads_zero: assert property (p_svc_reads_zero) // [RULE9]
        else $error("service register read nonzero");

    property p_wd_reset;
        wd_expire |=> sys_reset_out && cause_r[CAUSE_WDOG_BIT]
                      ##15 sys_reset_out ##1 !sys_reset_out;
    endproperty
    a_wd_reset: assert property (p_wd_reset) // [RULE8]
        else $error("watchdog timeout did not give reset pulse");

    property p_halt_reset;
        halt_in && ctrl_r.halt_mon_enable && !sys_reset_out
        |=> sys_reset_out && cause_r[CAUSE_HALT_BIT];
    endproperty
    a_halt_reset: assert property (p_halt_reset) // [RULE16] [RULE17]
        else $error("halt did not reset or record cause");

    property p_halt_off;
        !sys_reset_out && !ctrl_r.halt_mon_enable && !wd_expire
        |=> !sys_reset_out;
    endproperty
    a_halt_off: assert property (p_halt_off) // [RULE18]
        else $error("reset issued with halt monitor disabled");

    property p_wd_disabled;
        !ctrl_r.wdog_enable_bit |-> !wd_expire ##1 wd_cnt_r == '0;
    endproperty
    a_wd_disabled: assert property (p_wd_disabled) // [RULE5]
        else $error("disabled watchdog counted or expired");

    property p_bm_timeout;
        bm_fire |-> bm_cnt_r == bm_last && $past(bus_cycle_in.active)
                    ##1 bus_error_signal_out;
    endproperty
    a_bm_timeout: assert property (p_bm_timeout) // [RULE11] [RULE12]
        else $error("bus monitor fired at wrong count");

    property p_ext_unmonitored;
        bus_cycle_in.to_external && (!ctrl_r.bus_mon_enable
                                     || !bus_cycle_in.own_cpu)
        |-> !bm_fire;
    endproperty
    a_ext_unmonitored: assert property (p_ext_unmonitored) // [RULE13] [RULE14]
        else $error("external cycle timed without permission");

    property p_spurious;
        spurious |=> bus_error_signal_out;
    endproperty
    a_spurious: assert property (p_spurious) // [RULE19]
        else $error("spurious interrupt_acknowledge_cycle gave no bus error");

    c_restart:  cover property (svc_restart);
    c_wd_reset: cover property (wd_expire);
    c_halt:     cover property (halt_trig);
    c_bm:       cover property (bm_fire);

endmodule // system_protection_monitors
`default_nettype wire

// ===== test/bus_partner.sv
// Bus-side partner: one processor bus cycle with programmable answers
`timescale 1ns/1ps
`default_nettype none

module bus_partner (
    input  wire logic                        clock_in,
    input  wire logic                        go_in,
    input  wire sys_protect_pkg::bus_cycle_t tmpl_in,
    input  wire logic [6:0]                  ack_at_in,
    input  wire logic [6:0]                  arb_at_in,
    output var  sys_protect_pkg::bus_cycle_t bus_cycle_out
);
    import sys_protect_pkg::*;

    logic [6:0] cnt_r  = 7'h00;
    logic       flip_r = 1'b0;

    always_ff @(posedge clock_in) begin
        flip_r <= ~flip_r;
        cnt_r  <= go_in ? cnt_r + 7'h01 : 7'h00;
    end

    // Zero answer time means the slave never answers
    always_comb begin
        bus_cycle_out = tmpl_in;
        bus_cycle_out.active = go_in;
        bus_cycle_out.transfer_acknowledge =
            go_in && (ack_at_in != 7'h00) && (cnt_r >= ack_at_in);
        bus_cycle_out.arb_end =
            go_in && (arb_at_in != 7'h00) && (cnt_r == arb_at_in);
        // Released bus: qualifiers wander instead of holding old values
        if (!go_in) begin
            bus_cycle_out.to_external = flip_r;
            bus_cycle_out.own_cpu = ~flip_r;
            bus_cycle_out.interrupt_acknowledge_cycle = flip_r;
            bus_cycle_out.transfer_acknowledge = ~flip_r;
            bus_cycle_out.arb_end = flip_r;
            bus_cycle_out.interrupt_arbitration_id = {4{flip_r}};
        end
    end
endmodule // bus_partner

`default_nettype wire

// ===== test/system_protection_monitors_tb.sv
// Self-checking bench for the system protection monitors
`timescale 1ns/1ps
`default_nettype none

module system_protection_monitors_tb;
    import sys_protect_pkg::*;

    logic        clock_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [3:0]  address_in = 4'h0;
    logic        read_in = 1'b0;
    logic        write_in = 1'b0;
    logic [31:0] writedata_in = 32'h0;
    logic [3:0]  byteenable_in = 4'hF;
    logic [31:0] readdata_out;
    logic        waitrequest_out;
    logic        pin = 1'b1;
    logic        halt_in = 1'b0;
    bus_cycle_t  bc;
    bus_cycle_t  tmpl = '0;
    logic        go = 1'b0;
    logic [6:0]  ack_at = 7'h00;
    logic [6:0]  arb_at = 7'h00;
    logic        bus_err;
    logic        sys_rst;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          f;
    int          hi;
    int          seen;

    typedef struct {
        logic [7:0] ctrl;
        bus_cycle_t bc;
        int         ack;
        int         arb;
        int         err;
    } row_t;

    function automatic bus_cycle_t mk(logic e, logic o, logic i,
                                      logic [3:0] id);
        return {1'b0, e, o, i, 2'b00, id};
    endfunction

    row_t rows [11] = '{
        '{8'h00, mk(0, 1, 0, 4'h0), 0, 0, 64},
        '{8'h01, mk(0, 1, 0, 4'h0), 0, 0, 32},
        '{8'h02, mk(0, 1, 0, 4'h0), 0, 0, 16},
        '{8'h03, mk(0, 1, 0, 4'h0), 0, 0, 8},
        '{8'h03, mk(0, 1, 0, 4'h0), 7, 0, 0},
        '{8'h03, mk(1, 1, 0, 4'h0), 0, 0, 0},
        '{8'h07, mk(1, 1, 0, 4'h0), 0, 0, 8},
        '{8'h07, mk(1, 0, 0, 4'h0), 0, 0, 0},
        '{8'h03, mk(0, 1, 1, 4'h5), 0, 0, 8},
        '{8'h00, mk(0, 1, 1, 4'h0), 0, 1, 2},
        '{8'h00, mk(0, 1, 1, 4'h3), 3, 1, 0}
    };

    // Shortened watchdog: base 2^5 ticks, ref tick 2 clocks, prescale 4
    system_protection_monitors #(
        .REF_DIV   (2),
        .BASE_LOG2 (5),
        .PRESCALE  (4)
    ) i_system_protection_monitors (
        .clock_in             (clock_in),
        .rst_n_in             (rst_n_in),
        .address_in           (address_in),
        .read_in              (read_in),
        .write_in             (write_in),
        .writedata_in         (writedata_in),
        .byteenable_in        (byteenable_in),
        .readdata_out         (readdata_out),
        .waitrequest_out      (waitrequest_out),
        .clock_mode_pin_in    (pin),
        .halt_in              (halt_in),
        .bus_cycle_in         (bc),
        .bus_error_signal_out (bus_err),
        .sys_reset_out        (sys_rst)
    );

    bus_partner i_bus_partner (
        .clock_in      (clock_in),
        .go_in         (go),
        .tmpl_in       (tmpl),
        .ack_at_in     (ack_at),
        .arb_at_in     (arb_at),
        .bus_cycle_out (bc)
    );

    initial begin
        forever #5 clock_in = ~clock_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] s, input logic [31:0] e,
                         input string msg);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %0h expected %0h",
                     $time, msg, s, e);
        end
    endtask

    // Request held until waitrequest is sampled low
    task automatic xfer(input logic [3:0] a, input logic wr,
                        input logic [7:0] d, output logic [31:0] r);
        int i;
        @(posedge clock_in);
        address_in   <= a;
        write_in     <= wr;
        read_in      <= !wr;
        writedata_in <= {24'h0, d};
        for (i = 0; i < 50; i++) begin
            @(posedge clock_in);
            if (waitrequest_out === 1'b0) break;
        end
        r = readdata_out;
        write_in <= 1'b0;
        read_in  <= 1'b0;
        if (i == 50) begin
            check(0, 1, "bus answer timeout");
            finish_test();
        end
    endtask

    task automatic do_reset(input logic p);
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        pin      <= p;
        halt_in  <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
    endtask

    // First cycle with system reset high, and how many cycles it stood
    task automatic watch(input int n, output int first, output int high);
        first = 0;
        high  = 0;
        for (int i = 1; i <= n; i++) begin
            @(posedge clock_in);
            #1;
            if (sys_rst === 1'b1) begin
                high++;
                if (first == 0) first = i;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        foreach (rows[r]) begin
            do_reset(1'b1);
            xfer(CTRL_OFS, 1'b1, rows[r].ctrl, q);
            @(posedge clock_in);
            tmpl   <= rows[r].bc;
            ack_at <= rows[r].ack[6:0];
            arb_at <= rows[r].arb[6:0];
            go     <= 1'b1;
            seen = 0;
            for (int i = 0; i < 72; i++) begin
                #1;
                if (seen == 0 && bus_err === 1'b1) seen = i;
                @(posedge clock_in);
            end
            go <= 1'b0;
            check(seen, rows[r].err, "bus error cycle");
        end
        // Register rules and the service sequence
        do_reset(1'b0);
        xfer(CTRL_OFS, 1'b0, 8'h00, q);
        check(q, 32'h40, "prescale from pin low");
        do_reset(1'b1);
        xfer(CTRL_OFS, 1'b0, 8'h00, q);
        check(q, 32'h00, "prescale from pin high");
        xfer(CTRL_OFS, 1'b1, 8'h9F, q);
        xfer(CTRL_OFS, 1'b1, 8'h00, q);
        xfer(CTRL_OFS, 1'b0, 8'h00, q);
        check(q, 32'h9F, "control write once");
        xfer(SVC_OFS, 1'b1, SVC_SECOND, q);
        xfer(STATUS_OFS, 1'b0, 8'h00, q);
        check(q, 32'h1, "lone second byte");
        xfer(SVC_OFS, 1'b1, SVC_FIRST, q);
        xfer(SVC_OFS, 1'b0, 8'h00, q);
        check(q, 32'h0, "service reads zero");
        xfer(STATUS_OFS, 1'b0, 8'h00, q);
        check(q, 32'h3, "armed after first byte");
        xfer(SVC_OFS, 1'b1, 8'h12, q);
        xfer(STATUS_OFS, 1'b0, 8'h00, q);
        check(q, 32'h3, "other byte keeps state");
        xfer(SVC_OFS, 1'b1, SVC_SECOND, q);
        xfer(STATUS_OFS, 1'b0, 8'h00, q);
        check(q, 32'h5, "new timing after service");
        xfer(4'h2, 1'b0, 8'h00, q);
        check(q, 32'h0, "unmapped read");
        // Timing 1 unprescaled: 2^7 ticks of 2 clocks
        watch(200, f, hi);
        check(f, 0, "early watchdog reset");
        xfer(SVC_OFS, 1'b1, SVC_FIRST, q);
        xfer(SVC_OFS, 1'b1, SVC_SECOND, q);
        watch(200, f, hi);
        check(f, 0, "service restarts count");
        watch(80, f, hi);
        check(f != 0, 1, "watchdog reset issued");
        check(hi, 16, "reset pulse width");
        xfer(CAUSE_OFS, 1'b0, 8'h00, q);
        check(q, 32'h2, "watchdog cause");
        // Prescaled timing 0: 2^5 * 4 ticks of 2 clocks
        do_reset(1'b0);
        xfer(CTRL_OFS, 1'b1, 8'hC0, q);
        watch(200, f, hi);
        check(f, 0, "prescaled not early");
        watch(100, f, hi);
        check(f != 0, 1, "prescaled timeout");
        // Halt monitor enabled
        do_reset(1'b1);
        xfer(CTRL_OFS, 1'b1, 8'h08, q);
        @(posedge clock_in);
        halt_in <= 1'b1;
        watch(20, f, hi);
        check(f, 1, "halt reset next cycle");
        check(hi, 16, "halt reset width");
        @(posedge clock_in);
        halt_in <= 1'b0;
        xfer(CAUSE_OFS, 1'b0, 8'h00, q);
        check(q, 32'h1, "halt cause");
        xfer(CAUSE_OFS, 1'b1, 8'h03, q);
        xfer(CAUSE_OFS, 1'b0, 8'h00, q);
        check(q, 32'h0, "cause write one clears");
        // Halt disabled and watchdog off
        do_reset(1'b1);
        xfer(CAUSE_OFS, 1'b0, 8'h00, q);
        check(q, 32'h0, "cause cleared by pin");
        xfer(CTRL_OFS, 1'b1, 8'h00, q);
        @(posedge clock_in);
        halt_in <= 1'b1;
        watch(300, f, hi);
        check(f, 0, "no reset when off");
        finish_test();
    end
endmodule // system_protection_monitors_tb

`default_nettype wire
